// ==== src/holdoff_filter.sv ====
// Persistence filter: passes a condition once it has held for the hold-off time.
// Assumes step_tick is a one-cycle pulse per hold-off step.
`timescale 1ns/1ps
module holdoff_filter (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Condition and timing
	input wire logic raw,
	input wire logic step_tick,
	input wire logic [prot_pkg::HOLDOFF_W-1:0] period,
	output logic held
);
	localparam logic [prot_pkg::HOLDOFF_W-1:0] STEP = 7'h01;

	logic [prot_pkg::HOLDOFF_W-1:0] cnt_q;
	wire reached = (cnt_q >= period);

	always_ff @(posedge ref_clk)
	begin
		if (srst || !raw)
		begin
			cnt_q <= '0;
			held <= 1'b0;
		end
		else
		begin
			held <= reached;
			if (step_tick && !reached)
				cnt_q <= cnt_q + STEP;
		end
	end
endmodule : holdoff_filter

// ==== src/linear_protection_switch_controller.sv ====
// Linear protection switching controller: requests, priorities, bridge, selector, APS.
// Assumes path conditions, commands and the received word come from ref_clk logic.
//
// What this block does
// - Drive the protected group's bridge and selector choice.
// - Turn each path's fail and degrade into request type and path number.
// - Turn each operator command into request type and named signal number; lockout always gives signal zero.
// - Pick the single highest local request among signal, external and restore-state ones.
// - Decode received protocol word into type, signal and bridged signal; its architecture bit is not used.
// - Compare local winner with remote request and keep the higher.
// - Choose the normal or spare signal bridged onto protection.
// - Choose the normal or spare signal selected from protection.
// - Build transmitted word from local type (reverse request when remote wins), global signal, bridged signal, architecture.
// - Always report local status; remote status only with protocol word enabled.
// - Wait-to-restore time settable from zero to twelve minutes.
// - Hold-off time settable zero to ten seconds in 100 ms steps.
// - Fail and degrade from trail inputs; inherent kind uses server fail only.
// - Accept clear, lockout, forced, manual and exercise commands.
// - Fail and degrade request priorities each selectable low or high.
// - Word sent but received content ignored where protocol is not relied upon.
// - No bi-directional switching without a defined path protocol word.
// - Commands ranked clear, lockout, forced, manual, exercise; one active at once.
// - Refused commands are dropped; every command gets a done or reason response.
// - New fail or degrade pre-empts waiting; expiry gives no request, revert.
// - Protection is number zero, working paths one upward.
`timescale 1ns/1ps
module linear_protection_switch_controller #(
	parameter int STEP_CYCLES = prot_pkg::HOLDOFF_STEP_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Configuration
	input wire prot_pkg::cfg_t cfg,
	// Path conditions, index is the signal number
	input wire logic [prot_pkg::NUM_PATHS-1:0] server_fail_input,
	input wire logic [prot_pkg::NUM_PATHS-1:0] trail_fail_input,
	input wire logic [prot_pkg::NUM_PATHS-1:0] trail_degrade_input,
	// Operator commands
	input wire logic cmd_valid,
	input wire logic [prot_pkg::CMD_W-1:0] operator_command,
	input wire logic [prot_pkg::SIG_W-1:0] cmd_signal,
	// Command response
	output logic resp_valid,
	output logic resp_accepted,
	output logic [prot_pkg::RESP_W-1:0] resp_reason,
	// Protocol words
	input wire prot_pkg::aps_word_t aps_rx,
	output prot_pkg::aps_word_t aps_tx,
	// Bridge and selector
	output logic [prot_pkg::SIG_W-1:0] bridge_sig,
	output logic [prot_pkg::SIG_W-1:0] selector_sig,
	// Status
	output prot_pkg::request_t local_status,
	output prot_pkg::request_t remote_status,
	output logic restore_wait_active
);
	localparam int NP = prot_pkg::NUM_PATHS;
	localparam logic [NP-1:0] PATH_ONE = {{(NP-1){1'b0}}, 1'b1};
	localparam logic [prot_pkg::WTR_W-1:0] WTR_STEP = 10'h001;
	typedef enum logic [2:0] {
		RS_IDLE = 3'b001,
		RESTORE_WAIT_STATE = 3'b010,
		RS_NO_REVERT = 3'b100
	} restore_state_t;
	function automatic prot_pkg::request_t req_max(input prot_pkg::request_t a,
		input prot_pkg::request_t b);
		return (a.req >= b.req) ? a : b;
	endfunction : req_max
	// Requests under which normal traffic uses protection
	function automatic logic moves_traffic(input logic [prot_pkg::REQ_W-1:0] r);
		return (r == prot_pkg::REQ_DO_NOT_REVERT) ||
			((r >= prot_pkg::REQ_RESTORE_WAIT) && (r <= prot_pkg::REQ_FORCED));
	endfunction : moves_traffic
	function automatic logic [prot_pkg::REQ_W-1:0] cond_rank(input logic fail,
		input logic degrade, input logic is_prot, input prot_pkg::cfg_t c);
		logic [prot_pkg::REQ_W-1:0] r;
		r = prot_pkg::REQ_NO_REQUEST;
		if (fail && is_prot)
			r = prot_pkg::REQ_PROT_FAIL;
		else if (fail)
			r = c.fail_request_rank ? prot_pkg::REQ_FAIL_HIGH : prot_pkg::REQ_FAIL_LOW;
		else if (degrade)
			r = c.degrade_request_rank ? prot_pkg::REQ_DEGRADE_HIGH :
				prot_pkg::REQ_DEGRADE_LOW;
		return r;
	endfunction : cond_rank
	function automatic logic sig_allowed(input logic [prot_pkg::CMD_W-1:0] cmd,
		input logic [prot_pkg::SIG_W-1:0] s, input prot_pkg::cfg_t c);
		logic work;
		logic zero_ok;
		work = (s >= prot_pkg::SIG_FIRST_WORK) &&
			(c.architecture_select ? (s <= prot_pkg::SIG_LAST_WORK) :
			(s == prot_pkg::SIG_FIRST_WORK));
		zero_ok = (s == prot_pkg::SIG_PROT) && !c.architecture_select && !c.revert_select;
		unique case (cmd)
			prot_pkg::CLEAR_COMMANDS_CMD: return 1'b1;
			prot_pkg::LOCKOUT_PROTECTION_CMD: return 1'b1;
			prot_pkg::FORCED_SWITCH_CMD: return work || zero_ok ||
				(c.architecture_select && c.spare_traffic_enable && s == prot_pkg::SIG_SPARE);
			prot_pkg::MANUAL_SWITCH_CMD: return work || zero_ok;
			prot_pkg::EXERCISE_CMD: return work;
			default: return 1'b0;
		endcase
	endfunction : sig_allowed
	// Timing pulses
	logic step_tick;
	logic sec_tick;
	pulse_divider #(.DIV(STEP_CYCLES)) u_step_div (
		.ref_clk(ref_clk),
		.srst(srst),
		.en(1'b1),
		.tick(step_tick)
	);
	pulse_divider #(.DIV(prot_pkg::STEPS_PER_SEC)) u_sec_div (
		.ref_clk(ref_clk),
		.srst(srst),
		.en(step_tick),
		.tick(sec_tick)
	);
	// Path conditions through hold-off
	logic [NP-1:0] fail_held;
	logic [NP-1:0] degrade_held;
	logic [NP-1:0] path_defect;
	logic [prot_pkg::REQ_W-1:0] path_rank [NP];
	wire inherent = (cfg.protection_kind == prot_pkg::INHERENT_SUBNET_PROTECTION);
	genvar p;
	generate
		for (p = 0; p < NP; p++)
		begin : g_path
			wire raw_fail = inherent ? server_fail_input[p] : trail_fail_input[p];
			wire raw_degrade = !inherent && trail_degrade_input[p];
			holdoff_filter u_fail (
				.ref_clk(ref_clk),
				.srst(srst),
				.raw(raw_fail),
				.step_tick(step_tick),
				.period(cfg.holdoff_period),
				.held(fail_held[p])
			);
			holdoff_filter u_degrade (
				.ref_clk(ref_clk),
				.srst(srst),
				.raw(raw_degrade),
				.step_tick(step_tick),
				.period(cfg.holdoff_period),
				.held(degrade_held[p])
			);
			assign path_rank[p] = cond_rank(fail_held[p], degrade_held[p], p == 0, cfg);
			assign path_defect[p] = (path_rank[p] != prot_pkg::REQ_NO_REQUEST);
		end
	endgenerate
	// Signal request: highest condition, lower number wins a tie
	prot_pkg::request_t sig_req;
	always_comb
	begin
		sig_req = '0;
		for (int i = 0; i < NP; i++)
		begin
			if (path_rank[i] > sig_req.req)
			begin
				sig_req.req = path_rank[i];
				sig_req.sig = prot_pkg::SIG_W'(i);
			end
		end
	end
	// External request
	prot_pkg::request_t ext_q;
	prot_pkg::request_t cmd_req;
	logic [prot_pkg::SIG_W-1:0] selector_q;
	wire [prot_pkg::SIG_W-1:0] idle_sig = (cfg.architecture_select &&
		cfg.spare_traffic_enable) ? prot_pkg::SIG_SPARE : prot_pkg::SIG_PROT;
	wire [NP-1:0] cmd_mask = PATH_ONE << cmd_signal;
	wire other_defect = |(path_defect & ~cmd_mask);
	wire aps_en = cfg.protocol_word_enable;
	always_comb
	begin
		cmd_req.sig = cmd_signal;
		unique case (operator_command)
			prot_pkg::LOCKOUT_PROTECTION_CMD:
			begin
				cmd_req.req = prot_pkg::REQ_LOCKOUT;
				cmd_req.sig = prot_pkg::SIG_PROT;
			end
			prot_pkg::FORCED_SWITCH_CMD: cmd_req.req = prot_pkg::REQ_FORCED;
			prot_pkg::MANUAL_SWITCH_CMD: cmd_req.req = prot_pkg::REQ_MANUAL;
			prot_pkg::EXERCISE_CMD: cmd_req.req = prot_pkg::REQ_EXERCISE;
			default: cmd_req = '0;
		endcase
	end
	wire cmd_outranked = (operator_command != prot_pkg::CLEAR_COMMANDS_CMD) &&
		(operator_command == prot_pkg::EXERCISE_CMD ?
		(ext_q.req != prot_pkg::REQ_NO_REQUEST) : (ext_q.req >= cmd_req.req));
	wire cmd_state_bad =
		(operator_command == prot_pkg::FORCED_SWITCH_CMD && aps_en && fail_held[0]) ||
		(operator_command == prot_pkg::MANUAL_SWITCH_CMD && other_defect) ||
		(operator_command == prot_pkg::EXERCISE_CMD && selector_q != idle_sig);
	wire [prot_pkg::RESP_W-1:0] cmd_reason =
		!sig_allowed(operator_command, cmd_signal, cfg) ? prot_pkg::RESP_BAD_SIGNAL :
		cmd_outranked ? prot_pkg::RESP_OUTRANKED :
		cmd_state_bad ? prot_pkg::RESP_PATH_STATE : prot_pkg::RESP_DONE;
	wire cmd_ok = (cmd_reason == prot_pkg::RESP_DONE);
	wire ext_preempted = (ext_q.req == prot_pkg::REQ_MANUAL ||
		ext_q.req == prot_pkg::REQ_EXERCISE) && (sig_req.req > ext_q.req);
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			ext_q <= '0;
			resp_valid <= 1'b0;
			resp_accepted <= 1'b0;
			resp_reason <= prot_pkg::RESP_DONE;
		end
		else
		begin
			resp_valid <= cmd_valid;
			if (cmd_valid)
			begin
				resp_accepted <= cmd_ok;
				resp_reason <= cmd_reason;
			end
			if (cmd_valid && cmd_ok)
				ext_q <= cmd_req;
			else if (ext_preempted)
				ext_q <= '0;
		end
	end

	// Local priority and restore states
	restore_state_t rs_q;
	restore_state_t rs_d;
	prot_pkg::request_t prev_local_q;
	logic [prot_pkg::SIG_W-1:0] rs_sig_q;
	logic [prot_pkg::WTR_W-1:0] wtr_cnt_q;
	wire [prot_pkg::SIG_W-1:0] wait_sig = (rs_q == RS_IDLE) ? prev_local_q.sig : rs_sig_q;
	wire prot_pkg::request_t state_req = (rs_d == RESTORE_WAIT_STATE) ?
		{prot_pkg::REQ_RESTORE_WAIT, wait_sig} : (rs_d == RS_NO_REVERT) ?
		{prot_pkg::REQ_DO_NOT_REVERT, wait_sig} : '0;
	wire prot_pkg::request_t core_req = req_max(sig_req, ext_q);
	wire prot_pkg::request_t local_req = req_max(core_req, state_req);
	wire prev_work = (prev_local_q.sig != prot_pkg::SIG_PROT);
	wire below_wait = (core_req.req < prot_pkg::REQ_RESTORE_WAIT);
	wire failure_release = prev_work && below_wait &&
		(prev_local_q.req >= prot_pkg::REQ_DEGRADE_LOW) &&
		(prev_local_q.req <= prot_pkg::REQ_FAIL_HIGH);
	wire command_release = prev_work && below_wait && !cfg.revert_select &&
		(prev_local_q.req == prot_pkg::REQ_FORCED || prev_local_q.req == prot_pkg::REQ_MANUAL);
	wire wtr_done = (wtr_cnt_q >= cfg.restore_wait_period);
	always_comb
	begin
		rs_d = rs_q;
		unique case (rs_q)
			RS_IDLE:
			begin
				if (failure_release)
					rs_d = cfg.revert_select ? RESTORE_WAIT_STATE : RS_NO_REVERT;
				else if (command_release)
					rs_d = RS_NO_REVERT;
			end
			RESTORE_WAIT_STATE:
			begin
				if (core_req.req > prot_pkg::REQ_RESTORE_WAIT || wtr_done)
					rs_d = RS_IDLE;
			end
			RS_NO_REVERT:
			begin
				if (core_req.req > prot_pkg::REQ_DO_NOT_REVERT)
					rs_d = RS_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			rs_q <= RS_IDLE;
			rs_sig_q <= prot_pkg::SIG_PROT;
			wtr_cnt_q <= '0;
			prev_local_q <= '0;
		end
		else
		begin
			rs_q <= rs_d;
			prev_local_q <= local_req;
			if (rs_q == RS_IDLE)
				rs_sig_q <= prev_local_q.sig;
			if (rs_q != RESTORE_WAIT_STATE)
				wtr_cnt_q <= '0;
			else if (sec_tick && !wtr_done)
				wtr_cnt_q <= wtr_cnt_q + WTR_STEP;
		end
	end

	// Remote and global priority
	wire bi_eff = cfg.direction_select &&
		(cfg.protection_kind == prot_pkg::TRAIL_PROTECTION);
	wire remote_act = aps_en && bi_eff;
	wire prot_pkg::request_t remote_req = '{aps_rx.req, aps_rx.sig};
	wire remote_wins = remote_act && (remote_req.req > local_req.req) &&
		(remote_req.req != prot_pkg::REQ_REVERSE);
	wire prot_pkg::request_t global_req = remote_wins ? remote_req : local_req;
	wire prot_pkg::request_t tx_req = remote_wins ?
		'{prot_pkg::REQ_REVERSE, remote_req.sig} : local_req;
	wire switching = moves_traffic(global_req.req);
	wire [prot_pkg::SIG_W-1:0] target = switching ? global_req.sig : idle_sig;
	wire [prot_pkg::SIG_W-1:0] bridge_d = !cfg.architecture_select ?
		prot_pkg::SIG_FIRST_WORK : target;
	wire far_bridged = !remote_act || !cfg.architecture_select || (aps_rx.bridged == target);
	wire [prot_pkg::SIG_W-1:0] selector_d = far_bridged ? target : idle_sig;
	assign selector_sig = selector_q;
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			bridge_sig <= prot_pkg::SIG_PROT;
			selector_q <= prot_pkg::SIG_PROT;
			aps_tx <= '0;
			local_status <= '0;
			remote_status <= '0;
			restore_wait_active <= 1'b0;
		end
		else
		begin
			bridge_sig <= bridge_d;
			selector_q <= selector_d;
			aps_tx <= '{tx_req.req, tx_req.sig, bridge_d, cfg.architecture_select};
			local_status <= local_req;
			remote_status <= aps_en ? remote_req : '0;
			restore_wait_active <= (rs_d == RESTORE_WAIT_STATE);
		end
	end
endmodule : linear_protection_switch_controller

// ==== src/prot_pkg.sv ====
// Shared constants, codes and carriers of the linear protection controller.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package prot_pkg;
	// Signal numbering: protection is 0, working paths 1 upward, spare traffic last
	localparam int NUM_PATHS = 15;
	localparam int SIG_W = 4;
	localparam logic [SIG_W-1:0] SIG_PROT = 4'h0;
	localparam logic [SIG_W-1:0] SIG_FIRST_WORK = 4'h1;
	localparam logic [SIG_W-1:0] SIG_LAST_WORK = 4'hE;
	localparam logic [SIG_W-1:0] SIG_SPARE = 4'hF;

	// Request types; a larger code has the higher priority
	localparam int REQ_W = 4;
	localparam logic [REQ_W-1:0] REQ_NO_REQUEST = 4'h0;
	localparam logic [REQ_W-1:0] REQ_DO_NOT_REVERT = 4'h1;
	localparam logic [REQ_W-1:0] REQ_REVERSE = 4'h2;
	localparam logic [REQ_W-1:0] REQ_EXERCISE = 4'h4;
	localparam logic [REQ_W-1:0] REQ_RESTORE_WAIT = 4'h6;
	localparam logic [REQ_W-1:0] REQ_MANUAL = 4'h8;
	localparam logic [REQ_W-1:0] REQ_DEGRADE_LOW = 4'h9;
	localparam logic [REQ_W-1:0] REQ_DEGRADE_HIGH = 4'hA;
	localparam logic [REQ_W-1:0] REQ_FAIL_LOW = 4'hB;
	localparam logic [REQ_W-1:0] REQ_FAIL_HIGH = 4'hC;
	localparam logic [REQ_W-1:0] REQ_FORCED = 4'hD;
	localparam logic [REQ_W-1:0] REQ_PROT_FAIL = 4'hE;
	localparam logic [REQ_W-1:0] REQ_LOCKOUT = 4'hF;

	// Operator commands
	localparam int CMD_W = 3;
	localparam logic [CMD_W-1:0] CLEAR_COMMANDS_CMD = 3'h0;
	localparam logic [CMD_W-1:0] LOCKOUT_PROTECTION_CMD = 3'h1;
	localparam logic [CMD_W-1:0] FORCED_SWITCH_CMD = 3'h2;
	localparam logic [CMD_W-1:0] MANUAL_SWITCH_CMD = 3'h3;
	localparam logic [CMD_W-1:0] EXERCISE_CMD = 3'h4;

	// Command responses
	localparam int RESP_W = 2;
	localparam logic [RESP_W-1:0] RESP_DONE = 2'h0;
	localparam logic [RESP_W-1:0] RESP_OUTRANKED = 2'h1;
	localparam logic [RESP_W-1:0] RESP_PATH_STATE = 2'h2;
	localparam logic [RESP_W-1:0] RESP_BAD_SIGNAL = 2'h3;

	// Protection kinds
	localparam logic [1:0] INHERENT_SUBNET_PROTECTION = 2'h0;
	localparam logic [1:0] NONINTRUSIVE_SUBNET_PROTECTION = 2'h1;
	localparam logic [1:0] SUBLAYER_SUBNET_PROTECTION = 2'h2;
	localparam logic [1:0] TRAIL_PROTECTION = 2'h3;

	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int NS_PER_MS = 1000000;
	localparam int MS_PER_SEC = 1000;
	localparam int SEC_PER_MIN = 60;
	localparam int HOLDOFF_STEP_MS = 100;
	localparam int HOLDOFF_STEP_CYCLES = HOLDOFF_STEP_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int STEPS_PER_SEC = MS_PER_SEC / HOLDOFF_STEP_MS;
	localparam int HOLDOFF_MAX_SEC = 10;
	localparam int HOLDOFF_MAX_STEPS = HOLDOFF_MAX_SEC * STEPS_PER_SEC;
	localparam int WTR_MAX_MIN = 12;
	localparam int WTR_MAX_SEC = WTR_MAX_MIN * SEC_PER_MIN;
	localparam int HOLDOFF_W = 7;
	localparam int WTR_W = 10;

	typedef struct packed {
		logic [REQ_W-1:0] req;
		logic [SIG_W-1:0] sig;
	} request_t;

	typedef struct packed {
		logic [REQ_W-1:0] req;
		logic [SIG_W-1:0] sig;
		logic [SIG_W-1:0] bridged;
		logic arch;
	} aps_word_t;

	typedef struct packed {
		logic architecture_select;
		logic direction_select;
		logic revert_select;
		logic protocol_word_enable;
		logic spare_traffic_enable;
		logic fail_request_rank;
		logic degrade_request_rank;
		logic [1:0] protection_kind;
		logic [HOLDOFF_W-1:0] holdoff_period;
		logic [WTR_W-1:0] restore_wait_period;
	} cfg_t;
endpackage : prot_pkg

// ==== src/pulse_divider.sv ====
// One-cycle enable pulse every DIV enabled cycles.
// Assumes en comes from logic on ref_clk.
`timescale 1ns/1ps
module pulse_divider #(
	parameter int DIV = 10
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Count enable and pulse
	input wire logic en,
	output logic tick
);
	localparam int CW = $clog2(DIV + 1);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	localparam logic [CW-1:0] STEP = CW'(1);

	logic [CW-1:0] cnt_q;
	wire at_last = (cnt_q == LAST);

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			cnt_q <= '0;
			tick <= 1'b0;
		end
		else
		begin
			tick <= en & at_last;
			if (en)
				cnt_q <= at_last ? '0 : cnt_q + STEP;
		end
	end
endmodule : pulse_divider

// ==== verif/far_end_model.sv ====
// Far-end protection process: acknowledges sent requests after LAG cycles.
// Assumes ref_clk logic; force_en replaces the answer with force_word.
`timescale 1ns/1ps
module far_end_model #(
	parameter int LAG = 1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Protocol words
	input wire prot_pkg::aps_word_t aps_tx,
	input wire logic force_en,
	input wire prot_pkg::aps_word_t force_word,
	output prot_pkg::aps_word_t aps_rx
);
	prot_pkg::aps_word_t pipe_q [LAG];
	prot_pkg::aps_word_t answer_d;

	// Reverse request for the signal asked for, bridged at this end
	assign answer_d = (aps_tx.req > prot_pkg::REQ_REVERSE) ?
		{prot_pkg::REQ_REVERSE, aps_tx.sig, aps_tx.sig, aps_tx.arch} : '0;
	assign aps_rx = force_en ? force_word : pipe_q[LAG-1];

	always_ff @(posedge ref_clk)
	begin
		for (int i = LAG - 1; i > 0; i--)
			pipe_q[i] <= srst ? '0 : pipe_q[i-1];
		pipe_q[0] <= srst ? '0 : answer_d;
	end
endmodule : far_end_model

// ==== verif/prot_monitor.sv ====
// Port checker for the linear protection switch controller.
// Assumes it is bound to the top module; one clock, synchronous reset.
`timescale 1ns/1ps
module prot_monitor (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Inputs
	input wire prot_pkg::cfg_t cfg,
	input wire logic [prot_pkg::NUM_PATHS-1:0] server_fail_input,
	input wire logic [prot_pkg::NUM_PATHS-1:0] trail_fail_input,
	input wire logic cmd_valid,
	input wire logic [prot_pkg::CMD_W-1:0] operator_command,
	input wire logic [prot_pkg::SIG_W-1:0] cmd_signal,
	input wire prot_pkg::aps_word_t aps_rx,
	// Outputs
	input wire logic resp_valid,
	input wire logic resp_accepted,
	input wire logic [prot_pkg::RESP_W-1:0] resp_reason,
	input wire prot_pkg::aps_word_t aps_tx,
	input wire logic [prot_pkg::SIG_W-1:0] bridge_sig,
	input wire prot_pkg::request_t local_status,
	input wire prot_pkg::request_t remote_status
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);

	AST_RESP_NEXT: assert property (cmd_valid |=> resp_valid)
		else $error("no response after command");
	AST_RESP_CAUSE: assert property (resp_valid |-> $past(cmd_valid))
		else $error("response without command");
	AST_CLEAR_OK: assert property (
		cmd_valid && operator_command == prot_pkg::CLEAR_COMMANDS_CMD
		|=> resp_accepted && resp_reason == prot_pkg::RESP_DONE)
		else $error("clear not accepted");
	AST_BAD_CODE: assert property (
		cmd_valid && operator_command > prot_pkg::EXERCISE_CMD
		|=> !resp_accepted && resp_reason == prot_pkg::RESP_BAD_SIGNAL)
		else $error("unknown command not refused");
	AST_REMOTE_OFF: assert property (
		!cfg.protocol_word_enable |=> remote_status == '0)
		else $error("remote status without protocol word");
	AST_REMOTE_ON: assert property (
		cfg.protocol_word_enable |=> remote_status == {$past(aps_rx.req), $past(aps_rx.sig)})
		else $error("remote status not decoded");
	AST_TX_ARCH: assert property (
		$past(!srst) |-> aps_tx.arch == $past(cfg.architecture_select))
		else $error("sent architecture wrong");
	AST_TX_BRIDGE: assert property (
		local_status.req == prot_pkg::REQ_LOCKOUT && $past(cfg.architecture_select) &&
		!$past(cfg.spare_traffic_enable) |-> bridge_sig == prot_pkg::SIG_PROT &&
		aps_tx.bridged == prot_pkg::SIG_PROT)
		else $error("lockout leaves a signal bridged");
	AST_ONE_ONE: assert property (
		$past(!srst) && !$past(cfg.architecture_select) |-> bridge_sig == prot_pkg::SIG_FIRST_WORK)
		else $error("1+1 bridge not permanent");
	AST_FORCED_WIN: assert property (
		cmd_valid && operator_command == prot_pkg::FORCED_SWITCH_CMD && cmd_signal != '0
		&& server_fail_input == '0 && trail_fail_input == '0 ##1 resp_accepted
		|=> local_status == {prot_pkg::REQ_FORCED, $past(cmd_signal, 2)})
		else $error("forced switch not the local winner");

	cover property (resp_valid && !resp_accepted);
	cover property (local_status.req == prot_pkg::REQ_RESTORE_WAIT);
	cover property (remote_status.req == prot_pkg::REQ_REVERSE);
endmodule : prot_monitor

bind linear_protection_switch_controller prot_monitor prot_monitor_i (.ref_clk, .srst, .cfg,
	.server_fail_input, .trail_fail_input, .cmd_valid, .operator_command, .cmd_signal, .aps_rx,
	.resp_valid, .resp_accepted, .resp_reason, .aps_tx, .bridge_sig, .local_status,
	.remote_status);

// ==== verif/test_linear_protection_switch_controller.sv ====
// Self-checking bench for the protection controller with a far-end model.
// Assumes prot_pkg, the design, the model and the checker are compiled first.
`timescale 1ns/1ps
module test_linear_protection_switch_controller;
	localparam int STEP = 10;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	prot_pkg::cfg_t cfg;
	logic [prot_pkg::NUM_PATHS-1:0] server_fail_input, trail_fail_input, trail_degrade_input;
	logic cmd_valid, resp_valid, resp_accepted, restore_wait_active, force_en;
	logic [prot_pkg::CMD_W-1:0] operator_command;
	logic [prot_pkg::SIG_W-1:0] cmd_signal, bridge_sig, selector_sig;
	logic [prot_pkg::RESP_W-1:0] resp_reason;
	prot_pkg::aps_word_t aps_rx, aps_tx, force_word;
	prot_pkg::request_t local_status, remote_status;
	int errors = 0;
	int n_tests = 0;

	always #5 ref_clk = ~ref_clk;

	linear_protection_switch_controller #(.STEP_CYCLES(STEP))
		linear_protection_switch_controller_i (.ref_clk, .srst, .cfg, .server_fail_input,
		.trail_fail_input, .trail_degrade_input, .cmd_valid, .operator_command, .cmd_signal,
		.resp_valid, .resp_accepted, .resp_reason, .aps_rx, .aps_tx, .bridge_sig,
		.selector_sig, .local_status, .remote_status, .restore_wait_active);
	far_end_model #(.LAG(2)) far_end_model_i (.ref_clk, .srst, .aps_tx, .force_en,
		.force_word, .aps_rx);

	task automatic end_sim;
		if (errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	task automatic report(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : report

	task automatic check_req(input prot_pkg::request_t got, input prot_pkg::request_t exp);
		report(16'(got), 16'(exp));
	endtask : check_req

	task automatic check_sig(input logic [3:0] got, input logic [3:0] exp);
		report(16'(got), 16'(exp));
	endtask : check_sig

	task automatic check_bit(input logic got, input logic exp);
		report(16'(got), 16'(exp));
	endtask : check_bit

	task automatic settle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : settle

	task automatic wait_req(input logic [3:0] req, input int bound);
		int k = 0;
		while (local_status.req !== req && k < bound)
		begin
			@(negedge ref_clk);
			k++;
		end
		if (local_status.req !== req)
		begin
			errors++;
			$display("Error at %0t: wait got %h exp %h", $time, local_status.req, req);
			end_sim();
		end
	endtask : wait_req

	task automatic command(input logic [2:0] op, input logic [3:0] sig, input logic acc,
		input logic [1:0] why);
		@(negedge ref_clk);
		cmd_valid = 1'b1;
		operator_command = op;
		cmd_signal = sig;
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		report(16'({resp_valid, resp_accepted, resp_reason}), 16'({1'b1, acc, why}));
	endtask : command

	task automatic do_reset;
		srst = 1'b1;
		server_fail_input = '0;
		trail_fail_input = '0;
		trail_degrade_input = '0;
		force_en = 1'b0;
		settle(4);
		check_req(local_status, '0);
		srst = 1'b0;
	endtask : do_reset

	task automatic t_commands;
		cfg = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 2'h3, 7'h00, 10'h001};
		do_reset();
		command(prot_pkg::FORCED_SWITCH_CMD, 4'h3, 1'b1, prot_pkg::RESP_DONE);
		settle(1);
		check_req(local_status, {prot_pkg::REQ_FORCED, 4'h3});
		check_sig(bridge_sig, 4'h3);
		check_sig(selector_sig, 4'h3);
		command(prot_pkg::MANUAL_SWITCH_CMD, 4'h2, 1'b0, prot_pkg::RESP_OUTRANKED);
		command(prot_pkg::LOCKOUT_PROTECTION_CMD, 4'h0, 1'b1, prot_pkg::RESP_DONE);
		settle(1);
		check_req(local_status, {prot_pkg::REQ_LOCKOUT, 4'h0});
		check_sig(selector_sig, 4'h0);
		command(prot_pkg::FORCED_SWITCH_CMD, 4'h3, 1'b0, prot_pkg::RESP_OUTRANKED);
		command(3'h5, 4'h1, 1'b0, prot_pkg::RESP_BAD_SIGNAL);
		command(prot_pkg::CLEAR_COMMANDS_CMD, 4'h0, 1'b1, prot_pkg::RESP_DONE);
		command(prot_pkg::FORCED_SWITCH_CMD, 4'h0, 1'b0, prot_pkg::RESP_BAD_SIGNAL);
		command(prot_pkg::EXERCISE_CMD, 4'h2, 1'b1, prot_pkg::RESP_DONE);
		settle(1);
		check_req(local_status, {prot_pkg::REQ_EXERCISE, 4'h2});
		command(prot_pkg::MANUAL_SWITCH_CMD, 4'h2, 1'b1, prot_pkg::RESP_DONE);
		settle(1);
		check_req(local_status, {prot_pkg::REQ_MANUAL, 4'h2});
		cfg.spare_traffic_enable = 1'b1;
		command(prot_pkg::FORCED_SWITCH_CMD, 4'hF, 1'b1, prot_pkg::RESP_DONE);
		settle(1);
		check_sig(bridge_sig, 4'hF);
	endtask : t_commands

	task automatic t_holdoff;
		cfg = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 2'h3, 7'h02, 10'h002};
		do_reset();
		trail_fail_input[4] = 1'b1;
		trail_degrade_input[5] = 1'b1;
		settle(10);
		check_req(local_status, '0);
		wait_req(prot_pkg::REQ_FAIL_HIGH, 40);
		check_req(local_status, {prot_pkg::REQ_FAIL_HIGH, 4'h4});
		command(prot_pkg::MANUAL_SWITCH_CMD, 4'h2, 1'b0, prot_pkg::RESP_PATH_STATE);
		trail_fail_input[4] = 1'b0;
		settle(4);
		check_req(local_status, {prot_pkg::REQ_DEGRADE_LOW, 4'h5});
		trail_degrade_input[5] = 1'b0;
		settle(4);
		check_req(local_status, {prot_pkg::REQ_RESTORE_WAIT, 4'h5});
		check_bit(restore_wait_active, 1'b1);
		check_sig(selector_sig, 4'h5);
		trail_degrade_input[6] = 1'b1;
		wait_req(prot_pkg::REQ_DEGRADE_LOW, 40);
		settle(1);
		check_bit(restore_wait_active, 1'b0);
		trail_degrade_input[6] = 1'b0;
		settle(50);
		check_req(local_status, {prot_pkg::REQ_RESTORE_WAIT, 4'h6});
		wait_req(prot_pkg::REQ_NO_REQUEST, 300);
		settle(1);
		check_sig(selector_sig, 4'h0);
	endtask : t_holdoff

	task automatic t_inherent;
		cfg = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 7'h00, 10'h002};
		do_reset();
		trail_fail_input[1] = 1'b1;
		settle(4);
		check_req(local_status, '0);
		server_fail_input[1] = 1'b1;
		settle(4);
		check_req(local_status, {prot_pkg::REQ_FAIL_HIGH, 4'h1});
		check_sig(bridge_sig, 4'h1);
	endtask : t_inherent

	task automatic t_remote;
		cfg = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 2'h3, 7'h00, 10'h002};
		do_reset();
		command(prot_pkg::FORCED_SWITCH_CMD, 4'h1, 1'b1, prot_pkg::RESP_DONE);
		settle(2);
		check_req({aps_tx.req, aps_tx.sig}, {prot_pkg::REQ_FORCED, 4'h1});
		settle(6);
		check_req(remote_status, {prot_pkg::REQ_REVERSE, 4'h1});
		command(prot_pkg::CLEAR_COMMANDS_CMD, 4'h0, 1'b1, prot_pkg::RESP_DONE);
		force_word = {prot_pkg::REQ_FORCED, 4'h1, 4'h1, 1'b0};
		force_en = 1'b1;
		settle(5);
		check_req({aps_tx.req, aps_tx.sig}, {prot_pkg::REQ_REVERSE, 4'h1});
		cfg.direction_select = 1'b0;
		settle(4);
		check_req({aps_tx.req, aps_tx.sig}, '0);
		check_req(remote_status, {prot_pkg::REQ_FORCED, 4'h1});
		cfg.protocol_word_enable = 1'b0;
		settle(2);
		check_req(remote_status, '0);
	endtask : t_remote

	initial
	begin
		cfg = '0;
		server_fail_input = '0;
		trail_fail_input = '0;
		trail_degrade_input = '0;
		cmd_valid = 1'b0;
		operator_command = '0;
		cmd_signal = '0;
		force_en = 1'b0;
		force_word = '0;
		t_commands();
		t_holdoff();
		t_inherent();
		t_remote();
		end_sim();
	end
endmodule : test_linear_protection_switch_controller
